// >>> bcs_stream_port.sv
`timescale 1ns/1ns
// Function
// R1 - upstream marks first symbol with start
// R2 - output start only on first transfer
// R3 - offer new data only while ready
// R4 - valid low when nothing to offer
// R5 - valid exactly when data is valid
// R6 - input sink, output source, framed
// R7 - both links honour backpressure
// R8 - decoder output bus carries data plus count
// R9 - output end on last transfer
// R10 - count valid with output end
// R11 - transfer only when valid and ready
// R12 - after reset accept whole codewords only
// R13 - stalled output holds stable
module bcs_stream_port
  import bcs_pkg::*;
#(
  parameter int unsigned DATA_W  = DATA_W_DEF,
  parameter int unsigned COUNT_W = COUNT_W_DEF,
  parameter logic        DECODER = DECODER_DEF
)(
  // clock and reset
  input  wire logic               mclk_i,
  input  wire logic               reset_i,
  // input stream sink
  input  wire logic               in_valid_i,
  input  wire logic [DATA_W-1:0]  in_data_i,
  input  wire logic               in_sop_i,
  input  wire logic               in_eop_i,
  output logic                    in_ready_o,
  // processing core result for the symbol being taken
  input  wire logic [DATA_W-1:0]  proc_data_i,
  input  wire logic [COUNT_W-1:0] proc_count_i,
  // output stream source
  input  wire logic               sink_ready_i,
  output logic                    out_valid_o,
  output logic [DATA_W-1:0]       out_data_o,
  output logic                    out_sop_o,
  output logic                    out_eop_o,
  output logic [COUNT_W-1:0]      corrected_count_o,
  output logic [DATA_W+COUNT_W-1:0] out_bundle_o
);
  // =====================================================
  // data path overview
  // a symbol accepted on one edge is offered downstream on the next
  // core result, markers and count travel as one word and stall as one
  // symbols outside a codeword are taken off the link and discarded
  // in_ready_o follows sink_ready_i combinationally: a sink must not
  // derive its ready from this block's ready, or a loop forms
  // =====================================================
  // framing state
  typedef struct packed {
    bcs_frame_t frame;
  } bcs_state_t;

  localparam int unsigned SW = DATA_W + COUNT_W + 2;
  // stage word layout from the top: start, end, count, data
  localparam int unsigned SOP_POS = SW - 1;
  localparam int unsigned EOP_POS = SW - 2;
  localparam int unsigned CNT_HI  = DATA_W + COUNT_W - 1;
  localparam int unsigned CNT_LO  = DATA_W;

  bcs_state_t st_q, st_d;
  logic       take;
  logic       accept;
  logic       stage_free;
  logic       stage_valid;
  logic [SW-1:0] stage_in;
  logic [SW-1:0] stage_out;
  logic [COUNT_W-1:0] count_mux;

  // sink ready follows free room in the output stage
  assign in_ready_o = stage_free;              // R6 R7
  assign take       = in_valid_i && in_ready_o; // R11
  // drop symbols that do not belong to a started codeword
  assign accept     = take && (in_sop_i || st_q.frame == BCS_INPKT); // R12 R1

  // count only meaningful on the last symbol of a decoder codeword
  assign count_mux = (DECODER && in_eop_i) ? proc_count_i : '0; // R10
  assign stage_in  = {in_sop_i, in_eop_i, count_mux, proc_data_i};

  // =====================================================
  // frame tracking
  always_comb
  begin
    st_d = st_q;
    if (accept)
    begin
      case (st_q.frame)
        BCS_IDLE:  st_d.frame = in_eop_i ? BCS_IDLE : BCS_INPKT;
        BCS_INPKT: st_d.frame = in_eop_i ? BCS_IDLE : BCS_INPKT;
        default:   st_d.frame = BCS_IDLE;
      endcase
    end
  end

  // frame register
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      st_q.frame <= BCS_IDLE;
    else
      st_q <= st_d;
  end

  // =====================================================
  // output stage
  bcs_out_stage #(
    .W (SW)
  ) u_stage (
    .mclk_i       (mclk_i),
    .reset_i      (reset_i),
    .load_i       (accept),
    .word_i       (stage_in),
    .free_o       (stage_free),
    .sink_ready_i (sink_ready_i),
    .valid_o      (stage_valid),
    .word_o       (stage_out)
  );

  // output field split
  assign out_valid_o       = stage_valid;                               // R5 R3
  assign out_sop_o         = stage_valid && stage_out[SOP_POS];         // R2
  assign out_eop_o         = stage_valid && stage_out[EOP_POS];         // R9
  assign corrected_count_o = stage_out[CNT_HI:CNT_LO];                  // R10
  assign out_data_o        = stage_out[DATA_W-1:0];
  assign out_bundle_o      = {stage_out[DATA_W-1:0], corrected_count_o}; // R8

  // =====================================================
  // input side checks
  // room in the stage, either empty or draining, keeps the sink ready
  ready_free_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    !out_valid_o || sink_ready_i |-> in_ready_o) // R6 R7
    else $error("ready low with room in stage");

  // full and stalled stage refuses input
  ready_room_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    out_valid_o && !sink_ready_i |-> !in_ready_o) // R7
    else $error("ready high with full stage");

  // accepted symbol is offered on the next edge
  load_data_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    accept |=> out_valid_o && out_data_o == $past(proc_data_i)) // R5 R6
    else $error("accepted symbol not offered");

  // no output word without an input transfer
  no_take_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    !out_valid_o |=> !out_valid_o || $past(accept)) // R11
    else $error("output without input transfer");

  // =====================================================
  // framing checks
  // first accepted symbol of a codeword carries the start marker
  sop_first_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    accept && st_q.frame == BCS_IDLE |=> out_sop_o) // R2
    else $error("start marker missing on first word");

  // inner symbols carry no start marker
  sop_other_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    accept && st_q.frame == BCS_INPKT && !in_sop_i |=> !out_sop_o) // R2
    else $error("start marker on inner word");

  // last symbol carries the end marker
  eop_last_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    accept && in_eop_i |=> out_eop_o) // R9
    else $error("end marker missing");

  // an unfinished codeword leaves the frame open
  frame_open_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    accept && !in_eop_i |=> st_q.frame == BCS_INPKT) // R12
    else $error("frame not opened");

  // the end marker closes the frame
  frame_close_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    accept && in_eop_i |=> st_q.frame == BCS_IDLE) // R9 R12
    else $error("frame not closed");

  // no accepted transfer, no framing change
  frame_keep_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    !accept |=> st_q.frame == $past(st_q.frame)) // R11
    else $error("frame moved without transfer");

  // symbols outside a codeword are dropped
  orphan_drop_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    take && !in_sop_i && st_q.frame == BCS_IDLE && !out_valid_o |=> !out_valid_o) // R12
    else $error("orphan symbol forwarded");

  // leaving reset: empty stage, ready sink, closed frame
  release_clean_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    $fell(reset_i) |-> !out_valid_o && in_ready_o && st_q.frame == BCS_IDLE) // R12
    else $error("state not clean after reset");

  // =====================================================
  // output side checks
  // count of the codeword rides with its end marker
  count_eop_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    accept && in_eop_i && DECODER |=> corrected_count_o == $past(proc_count_i)) // R10
    else $error("count not presented with end");

  // inner words carry a zero count
  count_inner_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    accept && !in_eop_i |=> corrected_count_o == '0) // R10
    else $error("count on inner word");

  // stalled word keeps its data
  valid_hold_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    out_valid_o && !sink_ready_i |=> out_valid_o && $stable(out_data_o)) // R13
    else $error("data changed while stalled");

  // stalled word keeps its markers and count
  marker_stall_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    out_valid_o && !sink_ready_i |=> $stable(out_sop_o) && $stable(out_eop_o)
      && $stable(corrected_count_o)) // R13
    else $error("markers changed while stalled");

  // a taken word with nothing behind it leaves valid low
  drain_idle_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    out_valid_o && sink_ready_i && !accept |=> !out_valid_o) // R3 R4
    else $error("valid kept without new data");
endmodule : bcs_stream_port

// >>> bcs_pkg.sv
package bcs_pkg;
  // =====================================================
  // stream geometry and reset values
  localparam int unsigned DATA_W_DEF  = 20;
  localparam int unsigned COUNT_W_DEF = 8;
  localparam logic        DECODER_DEF = 1'b1;
  localparam logic        FLAG_RST    = 1'b0;

  // codeword framing state
  typedef enum logic [0:0] {
    BCS_IDLE,
    BCS_INPKT
  } bcs_frame_t;
endpackage : bcs_pkg

// >>> bcs_out_stage.sv
`timescale 1ns/1ns
// =====================================================
// output holding register: one-entry source stage
module bcs_out_stage
  import bcs_pkg::*;
#(
  parameter int unsigned W = 32
)(
  // clock and reset
  input  wire logic         mclk_i,
  input  wire logic         reset_i,
  // upstream side
  input  wire logic         load_i,
  input  wire logic [W-1:0] word_i,
  output logic              free_o,
  // downstream side
  input  wire logic         sink_ready_i,
  output logic              valid_o,
  output logic [W-1:0]      word_o
);
  typedef struct packed {
    logic         valid;
    logic [W-1:0] word;
  } bcs_stage_t;

  bcs_stage_t s_q, s_d;

  // accept a new word only when empty or draining this cycle
  assign free_o  = !s_q.valid || sink_ready_i; // R7
  assign valid_o = s_q.valid;                  // R5
  assign word_o  = s_q.word;

  // next state
  always_comb
  begin
    s_d = s_q;
    if (load_i && free_o)
    begin
      s_d.valid = 1'b1;
      s_d.word  = word_i;
    end
    else if (sink_ready_i)
    begin
      s_d.valid = FLAG_RST; // R4
    end
  end

  // state register
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // held word stays stable while stalled
  hold_stable_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    s_q.valid && !sink_ready_i |=> s_q.valid && $stable(s_q.word)) // R13
    else $error("output changed while stalled");
  // word leaves when downstream ready
  drain_step_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    s_q.valid && sink_ready_i && !load_i |=> !s_q.valid) // R3
    else $error("output not drained");
endmodule : bcs_out_stage

// >>> bcs_sink_model.sv
`timescale 1ns/1ns
// =====================================
// downstream sink model with stall patterns
module bcs_sink_model
(
  // clock and stall control
  input  wire logic       mclk_i,
  input  wire logic [1:0] mode_i,
  input  wire logic       rnd_i,
  // ready toward the codec
  output logic            sink_ready_o = 1'b1
);
  // ready moves after the falling edge: steady, toggling or random stalls
  always @(negedge mclk_i)
  begin
    sink_ready_o <= (mode_i == 2'h0) || (mode_i == 2'h1 && !sink_ready_o) || (mode_i == 2'h2 && rnd_i);
  end
endmodule : bcs_sink_model

// >>> tb_top.sv
`timescale 1ns/1ns
// =====================================
// stream port bench
module tb_top import bcs_pkg::*; ;
  logic        mclk_i = 0, reset_i = 1, in_valid_i = 0, in_sop_i = 0, in_eop_i = 0, in_pkt = 0, stalled = 0;
  logic [19:0] in_data_i = 0, proc_data_i = 0;
  logic [7:0]  proc_count_i = 0, corrected_count_o;
  logic [1:0]  mode = 0;
  logic [31:0] rs = 32'h4995, rr = 32'h4995;
  logic [29:0] exp_q[$], held, e;
  logic        in_ready_o, sink_ready_i, out_valid_o, out_sop_o, out_eop_o;
  logic [19:0] out_data_o;
  logic [27:0] out_bundle_o;
  int          err_count = 0, samples_checked = 0;
  // clock
  always #4 mclk_i = ~mclk_i;
  // free-running random source for the sink stalls, so stall runs always end
  always @(negedge mclk_i) rr <= lfsr(rr);
  bcs_stream_port DUT (.mclk_i(mclk_i), .reset_i(reset_i), .in_valid_i(in_valid_i), .in_data_i(in_data_i),
    .in_sop_i(in_sop_i), .in_eop_i(in_eop_i), .in_ready_o(in_ready_o), .proc_data_i(proc_data_i),
    .proc_count_i(proc_count_i), .sink_ready_i(sink_ready_i), .out_valid_o(out_valid_o), .out_data_o(out_data_o),
    .out_sop_o(out_sop_o), .out_eop_o(out_eop_o), .corrected_count_o(corrected_count_o), .out_bundle_o(out_bundle_o));
  bcs_sink_model sink (.mclk_i(mclk_i), .mode_i(mode), .rnd_i(rr[9]), .sink_ready_o(sink_ready_i));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic report_and_stop;
    if (err_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  // one symbol, held until taken; orphans outside a codeword are not expected back
  task automatic send(input logic s, input logic f);
    int n;
    @(negedge mclk_i);
    rs = lfsr(rs);
    {in_valid_i, in_sop_i, in_eop_i, in_data_i, proc_data_i, proc_count_i} = {1'b1, s, f, rs[19:0], rs[31:12], rs[7:0]};
    n = 0;
    do
    begin
      @(posedge mclk_i);
      n++;
    end
    while (in_ready_o !== 1'b1 && n < 64);
    if (in_ready_o !== 1'b1)
    begin
      err_count++;
      report_and_stop();
    end
    if (s || in_pkt)
    begin
      exp_q.push_back({proc_data_i, s, f, f ? proc_count_i : 8'h00});
      in_pkt = !f;
    end
  endtask : send
  // idle cycle with junk markers that must be ignored
  task automatic gap;
    @(negedge mclk_i);
    rs = lfsr(rs);
    {in_valid_i, in_sop_i, in_eop_i} = {1'b0, rs[1:0]};
  endtask : gap
  // watcher: each completed output transfer against the oldest note
  always @(posedge mclk_i)
  begin
    if (!reset_i && stalled)
      check("hold", {out_data_o, out_sop_o, out_eop_o, corrected_count_o}, held);
    if (!reset_i && out_valid_o === 1'b1 && sink_ready_i)
    begin
      e = exp_q.size() ? exp_q.pop_front() : 30'h0;
      check("word", {out_data_o, out_sop_o, out_eop_o, corrected_count_o}, e);
      check("bundle", out_bundle_o, {e[29:10], e[7:0]});
    end
    if (!reset_i && out_valid_o === 1'b1 && sink_ready_i === 1'b0)
      check("backpressure", in_ready_o, 0);
    stalled = !reset_i && out_valid_o === 1'b1 && !sink_ready_i;
    held = {out_data_o, out_sop_o, out_eop_o, corrected_count_o};
  end
  // main sequence over three stall patterns
  initial
  begin
    int len;
    repeat (16) @(posedge mclk_i);
    @(negedge mclk_i) reset_i = 0;
    for (int m = 0; m < 3; m++)
    begin
      mode = m[1:0];
      for (int p = 0; p < 8; p++)
      begin
        send(1'b0, rs[0]);
        len = 1 + int'(rs[2:0]);
        for (int k = 0; k < len; k++)
          send(k == 0, k == len - 1);
        if (rs[4])
          gap();
      end
    end
    // reset in mid-codeword: the frame must close and stale words vanish
    send(1'b1, 1'b0);
    send(1'b0, 1'b0);
    @(negedge mclk_i) reset_i = 1;
    @(negedge mclk_i) reset_i = 0;
    exp_q.delete();
    in_pkt = 0;
    send(1'b0, 1'b1);
    send(1'b1, 1'b1);
    gap();
    mode = 2'h0;
    for (int n = 0; n < 50 && exp_q.size() > 0; n++)
      @(negedge mclk_i);
    repeat (2) @(negedge mclk_i);
    check("drained", exp_q.size(), 0);
    check("idle", out_valid_o, 0);
    report_and_stop();
  end
endmodule : tb_top
